// File: bench/inr_operator.sv
// Operator stand-in: push-buttons, override link, loop current
`timescale 1ns/10ps
module inr_operator (
    input wire logic mclk,
    output inr_pkg::inr_keys_t keys,
    output logic [15:0] loopUa
);
    import inr_pkg::*;
    initial begin
        keys = '0;
        loopUa = 16'h2ee0;
    end
    // Gesture {P,E,Up,Down}; full release before the next one
    task automatic press(input logic [3:0] k);
        @(negedge mclk);
        keys[4:1] = k;
        repeat (4) @(negedge mclk);
        keys[4:1] = 4'h0;
        repeat (8) @(negedge mclk);
    endtask
    // Link and current change between clock edges
    task automatic setIn(input logic lnk, input logic [15:0] ua);
        @(negedge mclk);
        keys.link = lnk;
        loopUa = ua;
    endtask
endmodule

// File: bench/inr_panel_assertions.sv
// Port checker for the panel controller
`timescale 1ns/10ps
`include "inr_defs.svh"
module inr_panel_assertions #(
    parameter logic [31:0] PROMPT_CYCLES = 32'd20,
    parameter logic [31:0] INIT_CYCLES = 32'd10
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] loopUa,
    input wire logic [1:0] alarmEn,
    input wire inr_pkg::inr_disp_t disp,
    input wire inr_pkg::inr_bar_t bar,
    input wire inr_pkg::inr_cfg_t cfg,
    input wire logic storeReq
);
    import inr_pkg::*;
    // ****
    // Sequences
    // ****
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // Over-range current settled while the value is shown
    sequence overHeld;
        (loopUa > `INR_OVER_UA) [*3] ##0 disp.prompt == PR_VALUE;
    endsequence
    // Under-range current, still above the restart level
    sequence underHeld;
        (loopUa < `INR_UNDER_UA && loopUa >= `INR_RESTART_UA) [*3] ##0 disp.prompt == PR_VALUE;
    endsequence
    sequence scrollEnds;
        disp.prompt == PR_SCROLL ##1 disp.prompt != PR_SCROLL;
    endsequence
    // ****
    // Assertions
    // ****
    over_arrow_a: assert property (overHeld |-> bar.arrowUp)
        else $error("arrow missing on over-range current");
    under_bar_a: assert property (underHeld |-> bar.negSeg && bar.zeroBar)
        else $error("under-range bar missing");
    blank_cause_a: assert property (disp.blank |-> disp.overInd || disp.underInd)
        else $error("digits blanked without range flag");
    loss_init_a: assert property (loopUa < `INR_RESTART_UA |-> ##[1:3] disp.prompt == PR_INIT)
        else $error("no restart on loop loss");
    null_toggle_a: assert property ($changed(cfg.nullOn) |-> disp.prompt == PR_SETTING)
        else $error("deviation mode changed outside its item");
    capture_gate_a: assert property ($rose(disp.prompt == PR_NULL) |-> $past(alarmEn, 2) == 2'h0 && cfg.nullOn)
        else $error("capture taken while barred");
    scroll_entry_a: assert property ($rose(disp.prompt == PR_SCROLL) |-> $past(disp.prompt) == PR_DIGITS)
        else $error("scroll without code submission");
    scroll_exit_a: assert property (scrollEnds |-> disp.prompt inside {PR_ROOT_ITEM, PR_INIT})
        else $error("scroll did not lead to first item");
    store_source_a: assert property (storeReq |-> disp.prompt inside {PR_ZERO, PR_SPAN})
        else $error("store outside calibration");
    store_prompt_a: assert property (storeReq |=> !storeReq ##[0:2] disp.prompt == PR_STORE)
        else $error("store prompt missing");
endmodule
bind inr_panel inr_panel_assertions #(.PROMPT_CYCLES(PROMPT_CYCLES), .INIT_CYCLES(INIT_CYCLES))
    u_chk (.mclk(mclk), .rstn(rstn), .loopUa(loopUa), .alarmEn(alarmEn), .disp(disp),
    .bar(bar), .cfg(cfg), .storeReq(storeReq));

// File: bench/testbench.sv
// Self-checking bench for the panel controller
`timescale 1ns/10ps
module testbench;
    import inr_pkg::*;
    typedef struct packed {
        logic signed [17:0] raw;
        logic [15:0] ua;
        logic [1:0] ovUn;
    } inr_row_t;
    logic mclk;
    logic rstn = 1'b0;
    logic signed [17:0] rawValue = '0;
    logic [1:0] alarmEn = '0;
    logic storeBusy = 1'b0;
    logic signed [17:0] pctValue = 18'sh00123;
    logic signed [17:0] maValue = 18'sh00456;
    inr_keys_t keyPins;
    logic [15:0] loopUa;
    inr_disp_t disp;
    inr_bar_t bar;
    inr_cfg_t cfg;
    logic storeReq;
    logic calPoint;
    int failures = 0;
    int checked = 0;
    int nReq = 0;
    // Value, current, expected {over,under}
    inr_row_t rows [7] = '{'{18'sh00000, 16'h2ee0, 2'h0}, '{18'sh04e1f, 16'h2ee0, 2'h0},
        '{18'sh3b1e1, 16'h2ee0, 2'h0}, '{18'sh04e20, 16'h2ee0, 2'h2},
        '{18'sh3b1e0, 16'h2ee0, 2'h1}, '{18'sh00000, 16'h5209, 2'h2},
        '{18'sh00000, 16'h0dab, 2'h1}};
    inr_operator i_inr_operator (.mclk(mclk), .keys(keyPins), .loopUa(loopUa));
    // Short counts keep the run brief
    inr_panel #(.PROMPT_CYCLES(32'd20), .INIT_CYCLES(32'd10)) i_inr_panel (.mclk(mclk),
        .rstn(rstn), .keyPins(keyPins), .rawValue(rawValue), .pctValue(pctValue),
        .maValue(maValue), .loopUa(loopUa), .alarmEn(alarmEn), .storeBusy(storeBusy),
        .disp(disp), .bar(bar), .cfg(cfg), .storeReq(storeReq), .calPoint(calPoint));
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pk(input logic [3:0] k, input inr_prompt_t p);
        i_inr_operator.press(k);
        chk("prompt", disp.prompt, p);
    endtask
    task automatic test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #100000;
        failures++;
        test_done;
    end
    always @(posedge mclk) if (storeReq === 1'b1) nReq++;
    initial begin
        repeat (16) @(negedge mclk);
        chk("prompt", disp.prompt, PR_INIT);
        rstn = 1'b1;
        repeat (20) @(negedge mclk);
        chk("prompt", disp.prompt, PR_VALUE);
        foreach (rows[i]) begin
            rawValue = rows[i].raw;
            i_inr_operator.setIn(1'b0, rows[i].ua);
            repeat (4) @(negedge mclk);
            chk("over", disp.overInd, rows[i].ovUn[1]);
            chk("under", disp.underInd, rows[i].ovUn[0]);
            chk("arrow", bar.arrowUp, rows[i].ovUn[1]);
            chk("negseg", bar.negSeg, rows[i].ovUn[0]);
            chk("zerobar", bar.zeroBar, rows[i].ovUn[0]);
            chk("blank", disp.blank, |rows[i].ovUn);
        end
        rawValue = 18'sh001f4;
        i_inr_operator.setIn(1'b0, 16'h2ee0);
        pk(4'b1100, PR_CODE);
        pk(4'b1000, PR_DIGITS);
        pk(4'b0100, PR_SCROLL);
        repeat (25) @(negedge mclk);
        chk("prompt", disp.prompt, PR_ROOT_ITEM);
        pk(4'b0010, PR_CAL_ITEM);
        pk(4'b1000, PR_ZERO);
        pk(4'b0010, PR_SPAN);
        pk(4'b1000, PR_STORE);
        chk("calPoint", calPoint, 1'b1);
        chk("stores", nReq, 1);
        storeBusy = 1'b1;
        repeat (3) @(negedge mclk);
        storeBusy = 1'b0;
        repeat (6) @(negedge mclk);
        chk("prompt", disp.prompt, PR_SPAN);
        pk(4'b0100, PR_CAL_ITEM);
        pk(4'b0010, PR_COND_ITEM);
        pk(4'b1000, PR_WARN);
        pk(4'b1000, PR_FILTER);
        pk(4'b1000, PR_SETTING);
        pk(4'b0010, PR_SETTING);
        pk(4'b0100, PR_FILTER);
        pk(4'b0100, PR_COND_ITEM);
        pk(4'b0010, PR_PBTN_ITEM);
        pk(4'b1000, PR_SETTING);
        pk(4'b0010, PR_SETTING);
        pk(4'b0100, PR_PBTN_ITEM);
        chk("pctView", cfg.pctView, 1'b1);
        pk(4'b0010, PR_NULL_ITEM);
        pk(4'b1000, PR_SETTING);
        pk(4'b0001, PR_SETTING);
        pk(4'b0100, PR_NULL_ITEM);
        chk("nullOn", cfg.nullOn, 1'b1);
        pk(4'b0010, PR_CODE_ITEM);
        i_inr_operator.press(4'b1000);
        chk("code", disp.digits, 16'h0000);
        i_inr_operator.press(4'b0010);
        i_inr_operator.press(4'b1000);
        i_inr_operator.press(4'b0010);
        chk("code", disp.digits, 16'h0011);
        pk(4'b0100, PR_CODE_ITEM);
        pk(4'b0100, PR_VALUE);
        // P held alone: readout follows the percent input
        fork
            i_inr_operator.press(4'b1000);
            begin
                repeat (5) @(negedge mclk);
                chk("value", disp.value, pctValue);
            end
        join
        alarmEn = 2'h2;
        pk(4'b0101, PR_VALUE);
        alarmEn = 2'h0;
        pk(4'b0101, PR_NULL);
        repeat (25) @(negedge mclk);
        rawValue = 18'sh00258;
        repeat (4) @(negedge mclk);
        chk("value", disp.value, 18'sh00064);
        pk(4'b0101, PR_VALUE);
        chk("value", disp.value, 18'sh00064);
        i_inr_operator.setIn(1'b0, 16'h3e80);
        repeat (4) @(negedge mclk);
        chk("barlo", bar.lo, 7'h32);
        chk("barhi", bar.hi, 7'h4b);
        pk(4'b1100, PR_CODE);
        pk(4'b1000, PR_DIGITS);
        pk(4'b0100, PR_VALUE);
        pk(4'b1100, PR_CODE);
        for (int i = 0; i < 2; i++) begin
            i_inr_operator.press(4'b1000);
            i_inr_operator.press(4'b0010);
        end
        pk(4'b0100, PR_SCROLL);
        repeat (25) @(negedge mclk);
        pk(4'b0100, PR_VALUE);
        i_inr_operator.setIn(1'b1, 16'h2ee0);
        pk(4'b1100, PR_CODE);
        pk(4'b1000, PR_DIGITS);
        pk(4'b0100, PR_SCROLL);
        i_inr_operator.setIn(1'b0, 16'h07d0);
        repeat (4) @(negedge mclk);
        chk("prompt", disp.prompt, PR_INIT);
        test_done;
    end
endmodule

// File: core/inr_defs.svh
// Constants for the indicator null, security and range block
`ifndef INR_DEFS_SVH
`define INR_DEFS_SVH

// ****************************************************************
// Clock and prompt timing
// ****************************************************************
`define INR_CLK_KHZ 200000
`define INR_PROMPT_MS 2000
`define INR_INIT_MS 1000

// ****************************************************************
// Display and loop current limits
// ****************************************************************
`define INR_DISP_MAX 18'sh04e1f
`define INR_UNDER_UA 16'h0dac
`define INR_OVER_UA 16'h5208
`define INR_RESTART_UA 16'h0bb8
`define INR_ZERO_UA 16'h0fa0
`define INR_FULL_UA 16'h4e20
`define INR_BAR_SEGS 7'h64

// ****************************************************************
// Reset values
// ****************************************************************
`define INR_CODE_DEFAULT 16'h0000

`endif

// File: core/inr_key_sync.sv
// Push-button and link synchroniser with press detection
`timescale 1ns/10ps
module inr_key_sync (
    input wire logic mclk,
    input wire logic rstnSync,
    input wire inr_pkg::inr_keys_t pins,
    output inr_pkg::inr_keys_t level,
    output inr_pkg::inr_keys_t press
);
    import inr_pkg::*;

    inr_ksync_st_t r; // Whole state
    inr_ksync_st_t n; // Next state

    // ****************************************************************
    // Two-stage capture, then edge detect on the settled copy
    // ****************************************************************
    always_comb begin
        n = r;
        n.s1 = pins; // First stage, read only by the second
        n.s2 = r.s1;
        n.prev = r.s2;
    end

    // State register
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Press is one cycle; bounce filtering is left to the pad logic
    assign level = r.s2;
    assign press = r.s2 & ~r.prev;
endmodule

// File: core/inr_panel.sv
// Front-panel controller: null function, access code, range display
`timescale 1ns/10ps
`include "inr_defs.svh"
module inr_panel #(
    parameter logic [31:0] PROMPT_CYCLES = 32'(`INR_PROMPT_MS * `INR_CLK_KHZ),
    parameter logic [31:0] INIT_CYCLES = 32'(`INR_INIT_MS * `INR_CLK_KHZ)
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire inr_pkg::inr_keys_t keyPins,
    input wire logic signed [17:0] rawValue,
    input wire logic signed [17:0] pctValue,
    input wire logic signed [17:0] maValue,
    input wire logic [15:0] loopUa,
    input wire logic [1:0] alarmEn,
    input wire logic storeBusy,
    output inr_pkg::inr_disp_t disp,
    output inr_pkg::inr_bar_t bar,
    output inr_pkg::inr_cfg_t cfg,
    output logic storeReq,
    output logic calPoint
);
    import inr_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Step one BCD digit of a code, wrapping 0..9
    function automatic logic [15:0] inr_step(input logic [15:0] c, input logic [1:0] sel,
                                             input logic up);
        logic [3:0] d;
        logic [15:0] res;
        begin
            d = c[{sel, 2'b00} +: 4];
            if (up) begin
                d = (d == 4'h9) ? 4'h0 : d + 4'h1;
            end else begin
                d = (d == 4'h0) ? 4'h9 : d - 4'h1;
            end
            res = c;
            res[{sel, 2'b00} +: 4] = d;
            inr_step = res;
        end
    endfunction

    logic [1:0] rstPipe; // Reset release synchroniser
    logic rstnSync; // Released reset used everywhere else
    inr_keys_t kl; // Settled button levels
    inr_keys_t kp; // One-cycle press events
    inr_top_st_t r; // Whole state
    inr_top_st_t n; // Next state
    logic signed [17:0] adjValue; // Value after deviation offset
    logic overRange; // Computed or current over-range
    logic underRange; // Computed or current under-range
    logic [6:0] curBar; // Bar position of live current
    logic chordPE; // P and E pressed together
    logic chordDE; // Down and E pressed together
    logic soloP; // P alone
    logic soloE; // E alone
    logic codeOk; // Submitted code is accepted
    logic devActive; // Offset applies now

    // ****************************************************************
    // Reset release
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstnSync = rstPipe[1];

    // Buttons and override link come from pins
    inr_key_sync u_keys (
        .mclk(mclk),
        .rstnSync(rstnSync),
        .pins(keyPins),
        .level(kl),
        .press(kp)
    );

    // ****************************************************************
    // Deviation offset and range evaluation
    // ****************************************************************
    assign devActive = r.cfg.nullOn && r.refCaptured && (r.st != S_DEVSHOW);
    assign adjValue = devActive ? 18'(rawValue - r.refValue) : rawValue;

    inr_range_eval u_range (
        .value(adjValue),
        .currentUa(loopUa),
        .overRange(overRange),
        .underRange(underRange),
        .barPos(curBar)
    );

    // Chords win over single presses so a gesture never acts twice
    assign chordPE = kl.p && kl.e && (kp.p || kp.e);
    assign chordDE = kl.dn && kl.e && (kp.dn || kp.e);
    assign soloP = kp.p && !kl.e;
    assign soloE = kp.e && !kl.p && !kl.dn;

    // Override, zero code or exact match lets the operator in
    assign codeOk = kl.link || (r.effCode == `INR_CODE_DEFAULT)
                    || (r.entryCode == r.effCode);

    // ****************************************************************
    // Panel sequencer
    // ****************************************************************
    always_comb begin
        n = r;
        n.storeReq = 1'b0;
        if (r.timer != 32'h0) begin
            n.timer = r.timer - 32'h1;
        end
        case (r.st)
            // Power-up display sequence
            S_INIT: begin
                if (r.timer == 32'h0) begin
                    n.st = S_DISP;
                end
            end
            // Normal operation
            S_DISP: begin
                if (chordPE) begin
                    n.st = S_CODEPROMPT;
                end else if (chordDE && r.cfg.nullOn && !r.refCaptured
                             && (alarmEn == 2'h0)) begin
                    n.refValue = rawValue;
                    n.refBar = curBar;
                    n.refCaptured = 1'b1;
                    n.timer = PROMPT_CYCLES;
                    n.st = S_DEVSHOW;
                end
            end
            // Deviation prompt after a capture
            S_DEVSHOW: begin
                if (r.timer == 32'h0) begin
                    n.st = S_DISP;
                end
            end
            S_CODEPROMPT: begin
                if (soloP) begin
                    n.entryCode = 16'h0000;
                    n.digitSel = 2'h0;
                    n.st = S_CODEENTRY;
                end
            end
            S_CODEENTRY: begin
                if (kp.up || kp.dn) begin
                    n.entryCode = inr_step(r.entryCode, r.digitSel, kp.up);
                end else if (soloP) begin
                    n.digitSel = r.digitSel + 2'h1;
                end else if (soloE) begin
                    if (codeOk) begin
                        n.timer = PROMPT_CYCLES;
                        n.st = S_SCROLL;
                    end else begin
                        n.st = S_DISP;
                    end
                end
            end
            // Decimal points scroll, then first menu item
            S_SCROLL: begin
                if (r.timer == 32'h0) begin
                    n.item = M_ROOT;
                    n.st = S_MENU;
                end
            end
            // Main menu walk
            S_MENU: begin
                if (kp.up) begin
                    n.item = (r.item == M_CODE) ? M_ROOT : inr_item_t'(r.item + 3'h1);
                end else if (kp.dn) begin
                    n.item = (r.item == M_ROOT) ? M_CODE : inr_item_t'(r.item - 3'h1);
                end else if (soloE) begin
                    n.effCode = r.storedCode;
                    n.st = S_DISP;
                end else if (soloP) begin
                    n.digitSel = 2'h0;
                    case (r.item)
                        M_ROOT: n.st = S_ROOT;
                        M_CAL: n.st = S_CALLO;
                        M_COND: n.st = S_WARN;
                        M_PBTN: n.st = S_PBSEL;
                        M_NULL: n.st = S_NULLSEL;
                        M_CODE: n.st = S_CODEEDIT;
                        default: n.st = S_MENU;
                    endcase
                end
            end
            S_ROOT: begin
                if (kp.up || kp.dn) begin
                    n.cfg.rootOn = !r.cfg.rootOn;
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            // Deviation on/off; turning off re-arms the capture
            S_NULLSEL: begin
                if (kp.up || kp.dn) begin
                    n.cfg.nullOn = !r.cfg.nullOn;
                    if (r.cfg.nullOn) begin
                        n.refCaptured = 1'b0;
                    end
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            S_PBSEL: begin
                if (kp.up || kp.dn) begin
                    n.cfg.pctView = !r.cfg.pctView;
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            // Stored code shown and edited in place
            S_CODEEDIT: begin
                if (kp.up || kp.dn) begin
                    n.storedCode = inr_step(r.storedCode, r.digitSel, kp.up);
                end else if (soloP) begin
                    n.digitSel = r.digitSel + 2'h1;
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            // Conditioning warning, filter item, frequency
            S_WARN: begin
                if (soloP) begin
                    n.st = S_FILT;
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            S_FILT: begin
                if (soloP) begin
                    n.st = S_FREQ;
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            S_FREQ: begin
                if (kp.up || kp.dn) begin
                    n.cfg.filter60 = !r.cfg.filter60;
                end else if (soloE) begin
                    n.st = S_FILT;
                end
            end
            // Source calibration prompts; P stores the point
            S_CALLO, S_CALHI: begin
                if (kp.up) begin
                    n.st = S_CALHI;
                end else if (kp.dn) begin
                    n.st = S_CALLO;
                end else if (soloP) begin
                    n.calPoint = (r.st == S_CALHI);
                    n.storeReq = 1'b1;
                    n.storeSeen = 1'b0;
                    n.timer = PROMPT_CYCLES;
                    n.st = S_STORE;
                end else if (soloE) begin
                    n.st = S_MENU;
                end
            end
            // Timeout guards against a store that never answers
            S_STORE: begin
                if (storeBusy) begin
                    n.storeSeen = 1'b1;
                end
                if ((r.storeSeen && !storeBusy) || (r.timer == 32'h0)) begin
                    n.st = r.calPoint ? S_CALHI : S_CALLO;
                end
            end
            default: n.st = S_INIT;
        endcase

        // Loss of loop current overrides the next state and timer from any state
        if (loopUa < `INR_RESTART_UA) begin
            n.st = S_INIT;
            n.timer = INIT_CYCLES;
        end

        // Readout
        n.disp.value = adjValue;
        n.disp.blank = 1'b0;
        n.disp.underInd = 1'b0;
        n.disp.overInd = 1'b0;
        n.disp.digits = (r.st == S_CODEEDIT) ? r.storedCode : r.entryCode;
        n.disp.digitSel = r.digitSel;
        case (r.st)
            S_INIT: n.disp.prompt = PR_INIT;
            S_DEVSHOW: n.disp.prompt = PR_NULL;
            S_CODEPROMPT: n.disp.prompt = PR_CODE;
            S_CODEENTRY, S_CODEEDIT: n.disp.prompt = PR_DIGITS;
            S_SCROLL: n.disp.prompt = PR_SCROLL;
            S_MENU: n.disp.prompt = inr_prompt_t'(PR_ROOT_ITEM + r.item);
            S_ROOT, S_NULLSEL, S_PBSEL, S_FREQ: n.disp.prompt = PR_SETTING;
            S_WARN: n.disp.prompt = PR_WARN;
            S_FILT: n.disp.prompt = PR_FILTER;
            S_CALLO: n.disp.prompt = PR_ZERO;
            S_CALHI: n.disp.prompt = PR_SPAN;
            S_STORE: n.disp.prompt = PR_STORE;
            default: n.disp.prompt = PR_VALUE;
        endcase
        if (r.st == S_DISP) begin
            if (kl.p) begin
                n.disp.value = r.cfg.pctView ? pctValue : maValue;
            end else if (overRange || underRange) begin
                n.disp.blank = 1'b1;
                n.disp.overInd = overRange;
                n.disp.underInd = underRange && !overRange;
            end
        end

        // Bargraph, unaffected by the P-held readout
        n.bar = '0;
        if (overRange) begin
            n.bar.arrowUp = 1'b1;
        end else if (underRange) begin
            n.bar.negSeg = 1'b1;
            n.bar.zeroBar = 1'b1;
        end else if (devActive) begin
            n.bar.lo = (curBar < r.refBar) ? curBar : r.refBar;
            n.bar.hi = (curBar < r.refBar) ? r.refBar : curBar;
        end else begin
            n.bar.hi = curBar;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            r <= '0;
            r.st <= S_INIT;
            r.timer <= INIT_CYCLES;
            r.storedCode <= `INR_CODE_DEFAULT;
            r.effCode <= `INR_CODE_DEFAULT;
            r.disp.prompt <= PR_INIT;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign disp = r.disp;
    assign bar = r.bar;
    assign cfg = r.cfg;
    assign storeReq = r.storeReq;
    assign calPoint = r.calPoint;
endmodule

// File: core/inr_pkg.sv
// Types shared by the indicator null, security and range block
package inr_pkg;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic p;
        logic e;
        logic up;
        logic dn;
        logic link;
    } inr_keys_t;

    typedef enum logic [4:0] {
        PR_INIT, PR_VALUE, PR_NULL, PR_CODE, PR_DIGITS, PR_SCROLL,
        PR_ROOT_ITEM, PR_CAL_ITEM, PR_COND_ITEM, PR_PBTN_ITEM, PR_NULL_ITEM,
        PR_CODE_ITEM, PR_SETTING, PR_WARN, PR_FILTER, PR_ZERO, PR_SPAN, PR_STORE
    } inr_prompt_t;

    typedef enum logic [2:0] {
        M_ROOT, M_CAL, M_COND, M_PBTN, M_NULL, M_CODE
    } inr_item_t;

    typedef struct packed {
        inr_prompt_t prompt;
        logic signed [17:0] value;
        logic blank;
        logic underInd;
        logic overInd;
        logic [15:0] digits;
        logic [1:0] digitSel;
    } inr_disp_t;

    typedef struct packed {
        logic [6:0] lo;
        logic [6:0] hi;
        logic arrowUp;
        logic negSeg;
        logic zeroBar;
    } inr_bar_t;

    typedef struct packed {
        logic rootOn;
        logic filter60;
        logic pctView;
        logic nullOn;
    } inr_cfg_t;

    // ****************************************************************
    // Controller states
    // ****************************************************************
    typedef enum logic [4:0] {
        S_INIT, S_DISP, S_DEVSHOW, S_CODEPROMPT, S_CODEENTRY, S_SCROLL,
        S_MENU, S_ROOT, S_NULLSEL, S_PBSEL, S_CODEEDIT, S_WARN, S_FILT,
        S_FREQ, S_CALLO, S_CALHI, S_STORE
    } inr_state_t;

    typedef struct packed {
        inr_keys_t s1;
        inr_keys_t s2;
        inr_keys_t prev;
    } inr_ksync_st_t;

    typedef struct packed {
        inr_state_t st;
        inr_item_t item;
        logic [31:0] timer;
        inr_cfg_t cfg;
        logic refCaptured;
        logic signed [17:0] refValue;
        logic [6:0] refBar;
        logic [15:0] storedCode;
        logic [15:0] effCode;
        logic [15:0] entryCode;
        logic [1:0] digitSel;
        logic storeReq;
        logic calPoint;
        logic storeSeen;
        inr_disp_t disp;
        inr_bar_t bar;
    } inr_top_st_t;

endpackage

// File: core/inr_range_eval.sv
// Range check and bargraph position from loop current
`timescale 1ns/10ps
module inr_range_eval (
    input wire logic signed [17:0] value,
    input wire logic [15:0] currentUa,
    output logic overRange,
    output logic underRange,
    output logic [6:0] barPos
);
    `include "inr_defs.svh"
    import inr_pkg::*;

    localparam logic [15:0] UA_PER_SEG = 16'((`INR_FULL_UA - `INR_ZERO_UA) / `INR_BAR_SEGS);

    logic [15:0] aboveZero; // Current over the 4 mA point

    // ****************************************************************
    // Display range and current limits
    // ****************************************************************
    always_comb begin
        overRange = (value > `INR_DISP_MAX) || (currentUa > `INR_OVER_UA);
        underRange = (value < -`INR_DISP_MAX) || (currentUa < `INR_UNDER_UA);
    end

    // ****************************************************************
    // Bar follows calibration: 4 mA is zero, 20 mA full scale
    // ****************************************************************
    always_comb begin
        aboveZero = '0;
        if (currentUa <= `INR_ZERO_UA) begin
            barPos = '0;
        end else if (currentUa >= `INR_FULL_UA) begin
            barPos = `INR_BAR_SEGS;
        end else begin
            aboveZero = currentUa - `INR_ZERO_UA;
            barPos = 7'(aboveZero / UA_PER_SEG);
        end
    end
endmodule
